// >>> src/dacl_top.sv
`timescale 1ns/1ps
module dacl_top (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        chipSelect_n,
    input  wire logic        sclk,
    input  wire logic        serial_in,
    input  wire logic [17:0] resultA,
    input  wire logic [17:0] resultB,
    input  wire logic        selfTestOk,
    input  wire logic        cfgWrite,
    input  wire logic [17:0] upper_limit_value,
    input  wire logic [17:0] lower_limit_value,
    input  wire logic        extra_bits_enable,
    input  wire logic        osModeEnable,
    input  wire logic        output_lane_select,
    input  wire logic        limit_pin_enable,
    input  wire logic        power_down_select,
    input  wire logic        reference_source_select,
    input  wire logic        softReset,
    input  wire logic        hardReset,
    output logic             serial_out_a,
    output logic             serial_out_a_oe,
    output logic             serial_out_b_or_flag_pin,
    output logic             serial_out_b_or_flag_pin_oe,
    output logic [3:0]       limit_flag_register,
    output logic             selftest_fail_flag,
    output logic             analogPowerOn,
    output logic             internalRefEnable,
    output logic             sampleHold,
    output logic             convBusy,
    output logic [5:0]       frameClockCount,
    output logic             shortAccess
);
    logic [2:0]  csSync_q;
    logic [2:0]  sckSync_q;
    logic        csFall, csRise, sckRise, csLow;
    logic [17:0] upper_q, lower_q;
    logic        xbits_q, os_q, lane_q, pinEn_q, pdown_q, reference_source_select_q;
    logic [7:0]  oscDiv_q;
    logic        oscTick;
    logic [7:0]  convCnt_q;
    dacl_pkg::dacl_conv_t convState_q;
    logic        convEnd;
    logic [17:0] heldA_q, heldB_q;
    logic [3:0]  flags_q;
    logic        pinFlag_q;
    logic [35:0] shift_q;
    logic [5:0]  bitCnt_q;
    logic [5:0]  frameLen;
    logic        stRun_q;
    logic [7:0]  stCnt_q;
    logic        stFail_q;
    logic        extMode;
    logic        anyReset;
    logic        hiA, loA, hiB, loB;

    // pins from the host cross two flops; edges seen on stages 1 and 2 only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            csSync_q  <= 3'h7;
            sckSync_q <= 3'h0;
        end else begin
            csSync_q  <= {csSync_q[1:0], chipSelect_n};
            sckSync_q <= {sckSync_q[1:0], sclk};
        end
    end
    assign csLow   = ~csSync_q[1];
    assign csFall  = csSync_q[2] & ~csSync_q[1];
    assign csRise  = ~csSync_q[2] & csSync_q[1];
    assign sckRise = ~sckSync_q[2] & sckSync_q[1];
    assign anyReset = softReset | hardReset;

    // configuration held here; shutdown never touches it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            upper_q  <= dacl_pkg::UPPER_RST;
            lower_q  <= dacl_pkg::LOWER_RST;
            xbits_q  <= dacl_pkg::XBITS_RST;
            os_q     <= dacl_pkg::OS_RST;
            lane_q   <= dacl_pkg::LANE_RST;
            pinEn_q  <= dacl_pkg::PIN_EN_RST;
            pdown_q  <= dacl_pkg::PDOWN_RST;
            reference_source_select_q <= dacl_pkg::REFERENCE_SOURCE_SELECT_RST;
        end else if (hardReset) begin
            upper_q  <= dacl_pkg::UPPER_RST;
            lower_q  <= dacl_pkg::LOWER_RST;
            xbits_q  <= dacl_pkg::XBITS_RST;
            os_q     <= dacl_pkg::OS_RST;
            lane_q   <= dacl_pkg::LANE_RST;
            pinEn_q  <= dacl_pkg::PIN_EN_RST;
            pdown_q  <= dacl_pkg::PDOWN_RST;
            reference_source_select_q <= dacl_pkg::REFERENCE_SOURCE_SELECT_RST;
        end else if (cfgWrite) begin
            upper_q  <= upper_limit_value;
            lower_q  <= lower_limit_value;
            xbits_q  <= extra_bits_enable;
            os_q     <= osModeEnable;
            lane_q   <= output_lane_select;
            pinEn_q  <= limit_pin_enable;
            pdown_q  <= power_down_select;
            reference_source_select_q <= reference_source_select;
        end
    end

    // power and reference steering
    assign analogPowerOn     = ~pdown_q;
    assign internalRefEnable = ~pdown_q & ~reference_source_select_q;

    // internal oscillator as an enable; hard reset restarts it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oscDiv_q <= 8'h00;
        end else if (hardReset || oscDiv_q == dacl_pkg::OSC_DIV - 8'h01) begin
            oscDiv_q <= 8'h00;
        end else begin
            oscDiv_q <= oscDiv_q + 8'h01;
        end
    end
    assign oscTick = (oscDiv_q == dacl_pkg::OSC_DIV - 8'h01);

    // conversion timing from oscillator ticks only, never from sclk
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            convState_q <= dacl_pkg::DACL_IDLE;
            convCnt_q   <= 8'h00;
        end else if (anyReset) begin
            convState_q <= dacl_pkg::DACL_IDLE;
            convCnt_q   <= 8'h00;
        end else begin
            case (convState_q)
                dacl_pkg::DACL_IDLE: begin
                    if (csFall && !pdown_q) begin
                        convState_q <= dacl_pkg::DACL_CONV;
                        convCnt_q   <= 8'h00;
                    end
                end
                dacl_pkg::DACL_CONV: begin
                    if (oscTick) begin
                        if (convCnt_q == dacl_pkg::CONV_CYCLES - 8'h01) begin
                            convState_q <= dacl_pkg::DACL_DONE;
                        end
                        convCnt_q <= convCnt_q + 8'h01;
                    end
                end
                dacl_pkg::DACL_DONE: begin
                    convState_q <= dacl_pkg::DACL_IDLE;
                end
                default: begin
                    convState_q <= dacl_pkg::DACL_IDLE;
                end
            endcase
        end
    end
    assign convEnd  = (convState_q == dacl_pkg::DACL_DONE);
    assign convBusy = (convState_q == dacl_pkg::DACL_CONV);

    // sample captured at chip select fall (track-and-hold in hold)
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sampleHold <= 1'b0;
            heldA_q    <= 18'h00000;
            heldB_q    <= 18'h00000;
        end else begin
            if (csFall) begin
                sampleHold <= 1'b1;
                heldA_q    <= resultA;
                heldB_q    <= resultB;
            end else if (convEnd || anyReset) begin
                sampleHold <= 1'b0;
            end
        end
    end

    // shared limits for both channels
    assign hiA = (heldA_q > upper_q);
    assign loA = (heldA_q < lower_q);
    assign hiB = (heldB_q > upper_q);
    assign loB = (heldB_q < lower_q);

    // status flags reflect the latest conversion; reset clears them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= 4'h0;
        end else if (anyReset) begin
            flags_q <= 4'h0;
        end else if (convEnd) begin
            flags_q <= {loB, hiB, loA, hiA};
        end
    end
    assign limit_flag_register = flags_q;

    // pin flag: set at conversion end wins over the chip select clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinFlag_q <= 1'b0;
        end else if (convEnd) begin
            pinFlag_q <= hiA | loA | hiB | loB;
        end else if (csFall || anyReset) begin
            pinFlag_q <= 1'b0;
        end
    end

    // extra bits need a valid oversampling mode as well
    assign extMode = xbits_q & os_q;
    always_comb begin
        case ({lane_q, extMode})
            2'b00:   frameLen = dacl_pkg::CNT_TWO_STD;
            2'b01:   frameLen = dacl_pkg::CNT_TWO_EXT;
            2'b10:   frameLen = dacl_pkg::CNT_ONE_STD;
            default: frameLen = dacl_pkg::CNT_ONE_EXT;
        endcase
    end

    // readout shifter: previous results load at chip select fall
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_q  <= 36'h000000000;
            bitCnt_q <= 6'h00;
        end else if (anyReset) begin
            shift_q  <= 36'h000000000;
            bitCnt_q <= 6'h00;
        end else if (csFall) begin
            bitCnt_q <= 6'h00;
            if (extMode) begin
                shift_q <= {heldA_q, heldB_q};
            end else begin
                shift_q <= {heldA_q[17:2], heldB_q[17:2], 4'h0};
            end
        end else if (csLow && sckRise) begin
            bitCnt_q <= (bitCnt_q == 6'h3f) ? bitCnt_q : bitCnt_q + 6'h01;
            if (lane_q) begin
                shift_q <= {shift_q[34:0], 1'b0};
            end else if (extMode) begin
                shift_q <= {shift_q[34:18], 1'b0, shift_q[16:0], 1'b0};
            end else begin
                shift_q <= {shift_q[34:20], 1'b0, shift_q[18:4], 1'b0,
                            4'h0};
            end
        end
    end
    assign frameClockCount = bitCnt_q;

    // short frame: fewer than 16 clocks, or fewer than the readout needs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shortAccess <= 1'b0;
        end else if (csRise) begin
            shortAccess <= (bitCnt_q < dacl_pkg::CNT_REG_MIN) ||
                           (bitCnt_q < frameLen);
        end
    end

    // output drivers: lane b carries data or the limit flag
    always_comb begin
        serial_out_a    = shift_q[35];
        serial_out_a_oe = csLow;
        serial_out_b_or_flag_pin_oe = csLow;
        if (!lane_q) begin
            serial_out_b_or_flag_pin = extMode ? shift_q[17]
                                               : shift_q[19];
        end else if (pinEn_q) begin
            serial_out_b_or_flag_pin    = pinFlag_q;
            serial_out_b_or_flag_pin_oe = 1'b1;
        end else begin
            serial_out_b_or_flag_pin = 1'b0;
        end
    end

    // self test after power-on or hard reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stRun_q  <= 1'b1;
            stCnt_q  <= 8'h00;
            stFail_q <= 1'b0;
        end else if (hardReset) begin
            stRun_q  <= 1'b1;
            stCnt_q  <= 8'h00;
            stFail_q <= 1'b0;
        end else if (stRun_q) begin
            stCnt_q <= stCnt_q + 8'h01;
            if (stCnt_q == dacl_pkg::SELFTEST_LEN - 8'h01) begin
                stRun_q  <= 1'b0;
                stFail_q <= ~selfTestOk;
            end
        end
    end
    assign selftest_fail_flag = stFail_q;

    // the hiA flag follows the held result one cycle after conversion end
    flag_update_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        convEnd && !anyReset |=> flags_q[0] == $past(hiA))
        else $error("limit flag not updated at conversion end");
    pin_clear_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        csFall && !convEnd |=> !pinFlag_q)
        else $error("pin flag not cleared by chip select fall");
    conv_len_a: assert property (
        @(posedge clock) disable iff (!rst_n || softReset || hardReset)
        $rose(convBusy) && !anyReset && !hardReset |-> convBusy [*8])
        else $error("conversion ended too early");
    ref_enable_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        internalRefEnable |-> !pdown_q && !reference_source_select_q)
        else $error("internal reference on while off");
    out_release_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        csFall |-> serial_out_a_oe)
        else $error("lane a not driven in frame");
    soft_clear_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        softReset |=> limit_flag_register == 4'h0)
        else $error("soft reset left flags set");
    hard_default_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        hardReset |=> !pdown_q && upper_q == dacl_pkg::UPPER_RST)
        else $error("hard reset kept configuration");
    shut_power_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        pdown_q |-> !analogPowerOn && !internalRefEnable)
        else $error("analog alive in shutdown");

    // load paths; a stuck register would slip past the checks above
    cfg_keep_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !cfgWrite && !hardReset |=> $stable(upper_q) && $stable(lower_q)
            && $stable(lane_q) && $stable(reference_source_select_q))
        else $error("configuration moved without a write");
    ref_load_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        cfgWrite && !hardReset |=> internalRefEnable ==
            (!$past(power_down_select) && !$past(reference_source_select)))
        else $error("reference enable does not follow the written bits");
    count_step_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        csLow && sckRise && !csFall && !anyReset && bitCnt_q != 6'h3f
            |=> bitCnt_q == $past(bitCnt_q) + 6'h01)
        else $error("serial clock count missed a rise");
    selftest_end_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        stRun_q && !hardReset && stCnt_q == dacl_pkg::SELFTEST_LEN - 8'h01
            |=> selftest_fail_flag == !$past(selfTestOk))
        else $error("self test flag does not match its outcome");
    pin_set_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        convEnd |=> pinFlag_q == ($past(hiA) || $past(loA) || $past(hiB)
            || $past(loB)))
        else $error("pin flag not set from the limit flags");
endmodule

// >>> src/dacl_pkg.sv
// Behaviour
// - 16-bit results; 18 bits in 18 clocks with extra bits and oversampling
// - a limit event fires when a result is above upper or below lower limit
// - both channels share one upper and one lower limit value
// - two limit status flags per channel, one high and one low
// - common limit indication is the OR of all flags, driven on shared pin
// - limit pin and status flags update at end of every conversion
// - limit pin indication clears on every chip select falling edge; a conversion end in the same cycle sets it instead
// - power down select low is normal mode, high is shutdown
// - shutdown powers down analog and reference; serial port stays alive
// - configuration values survive entering and leaving shutdown
// - reference select low enables internal buffer, high uses external pin
// - soft reset keeps settings, restarts logic, clears history and flags; a conversion end in the same cycle sets the limit pin flag instead
// - hard reset does a soft reset and also restores defaults and oscillator
// - self test runs after power-on or hard reset and sets a fail flag
// - chip select fall holds the sample and releases the serial outputs
// - conversions are timed by the internal oscillator, not the serial clock
// - lane select chooses two-lane or single-lane result output
// - two-lane mode puts channel A on lane a and channel B on lane b
// - single-lane mode sends channel A then channel B on lane a
// - chip select fall starts both conversions, results read on next access
package dacl_pkg;
    localparam int unsigned RES_BITS      = 16;
    localparam int unsigned EXT_BITS      = 18;
    localparam int unsigned SHIFT_BITS    = 2 * EXT_BITS;
    localparam logic [5:0]  CNT_TWO_STD   = 6'h10;
    localparam logic [5:0]  CNT_TWO_EXT   = 6'h12;
    localparam logic [5:0]  CNT_ONE_STD   = 6'h20;
    localparam logic [5:0]  CNT_ONE_EXT   = 6'h24;
    localparam logic [5:0]  CNT_REG_MIN   = 6'h10;
    localparam logic [7:0]  CONV_CYCLES   = 8'h08;
    localparam logic [7:0]  OSC_DIV       = 8'h02;
    localparam logic [7:0]  SELFTEST_LEN  = 8'h04;
    localparam logic [17:0] UPPER_RST     = 18'h3ffff;
    localparam logic [17:0] LOWER_RST     = 18'h00000;
    localparam logic        LANE_RST      = 1'b0;
    localparam logic        PIN_EN_RST    = 1'b0;
    localparam logic        XBITS_RST     = 1'b0;
    localparam logic        OS_RST        = 1'b0;
    localparam logic        PDOWN_RST     = 1'b0;
    localparam logic        REFERENCE_SOURCE_SELECT_RST    = 1'b0;
    localparam int unsigned FLAG_HI_A     = 0;
    localparam int unsigned FLAG_LO_A     = 1;
    localparam int unsigned FLAG_HI_B     = 2;
    localparam int unsigned FLAG_LO_B     = 3;
    typedef enum logic [2:0] {
        DACL_IDLE = 3'b001,
        DACL_CONV = 3'b010,
        DACL_DONE = 3'b100
    } dacl_conv_t;
endpackage

// >>> verif/dacl_host_model.sv
`timescale 1ns/1ps
// serial host; sclk idles low between frames, frames open off clock edges
module dacl_host_model (
    output logic      chipSelect_n,
    output logic      sclk,
    output logic      serial_in,
    input  wire logic laneA,
    input  wire logic laneB
);
    initial begin
        chipSelect_n = 1'b1;
        sclk         = 1'b0;
        serial_in    = 1'b0;
    end
    // settle time lets the device see the fall before the first bit
    task automatic beginFrame();
        #13;
        chipSelect_n = 1'b0;
        #800;
    endtask
    // sample ahead of each rise, so each bit has sat a whole low phase
    task automatic shiftBits(input int bits, output logic [35:0] capA,
                             output logic [35:0] capB);
        capA = '0;
        capB = '0;
        for (int i = 0; i < bits; i++) begin
            capA = {capA[34:0], laneA};
            capB = {capB[34:0], laneB};
            sclk = 1'b1;
            #400;
            sclk = 1'b0;
            serial_in = ~serial_in; // data line toggles once per bit inside a frame
            #400;
        end
    endtask
    // release, then leave room for the conversion to finish
    task automatic endFrame();
        chipSelect_n = 1'b1;
        #4000;
    endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [17:0] a, b, up, lo;
        logic        lane, xb, os;
    } dacl_row_t;
    // upper limit always kept above lower
    dacl_row_t   rows [6] = '{
        '{18'h20000, 18'h10000, 18'h30000, 18'h08000, 1'b0, 1'b0, 1'b0},
        '{18'h3ffff, 18'h00001, 18'h30000, 18'h00100, 1'b0, 1'b0, 1'b0},
        '{18'h00010, 18'h3a5c3, 18'h20000, 18'h00100, 1'b1, 1'b0, 1'b0},
        '{18'h2b7e5, 18'h15a3c, 18'h2b7e4, 18'h15a3d, 1'b0, 1'b1, 1'b1},
        '{18'h2b7e4, 18'h15a3d, 18'h2b7e4, 18'h15a3d, 1'b1, 1'b1, 1'b1},
        '{18'h12345, 18'h0abcd, 18'h3fff0, 18'h00010, 1'b0, 1'b1, 1'b0}};
    logic        clock, rst_n, selfTestOk, cfgWrite, softReset, hardReset;
    logic        extra_bits_enable, osModeEnable, output_lane_select;
    logic        limit_pin_enable, power_down_select, reference_source_select;
    logic [17:0] resultA, resultB, upper_limit_value, lower_limit_value;
    wire logic   chipSelect_n, sclk, serial_in;
    logic        serial_out_a, serial_out_a_oe, serial_out_b_or_flag_pin;
    logic        serial_out_b_or_flag_pin_oe, selftest_fail_flag, ext;
    logic        analogPowerOn, internalRefEnable, convBusy, shortAccess;
    logic        sampleHold;
    logic [5:0]  frameClockCount;
    logic [3:0]  limit_flag_register;
    logic [35:0] capA, capB, expA, expB;
    int          nMismatch, checkCount, cycles, n;
    dacl_row_t   w;
    // a lane not driven floats instead of showing a stale bit
    wire logic   laneA = serial_out_a_oe ? serial_out_a : 1'bz;
    wire logic   laneB = serial_out_b_or_flag_pin_oe ?
                         serial_out_b_or_flag_pin : 1'bz;
    wire logic   flagPin = serial_out_b_or_flag_pin;

    dacl_top u_dacl_top (
        .clock, .rst_n, .chipSelect_n, .sclk, .serial_in, .resultA, .resultB,
        .selfTestOk, .cfgWrite, .upper_limit_value, .lower_limit_value,
        .extra_bits_enable, .osModeEnable, .output_lane_select,
        .limit_pin_enable, .power_down_select, .reference_source_select,
        .softReset, .hardReset, .serial_out_a, .serial_out_a_oe,
        .serial_out_b_or_flag_pin, .serial_out_b_or_flag_pin_oe,
        .limit_flag_register, .selftest_fail_flag, .analogPowerOn,
        .internalRefEnable, .sampleHold, .convBusy, .frameClockCount,
        .shortAccess);
    dacl_host_model u_dacl_host_model (
        .chipSelect_n, .sclk, .serial_in, .laneA, .laneB);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // hang guard, well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            completeRun();
        end
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic completeRun();
        $display("checks=%0d mismatches=%0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic writeCfg();
        cfgWrite = 1'b1;
        @(negedge clock);
        cfgWrite = 1'b0;
    endtask
    // one whole access; oe and busy looked at once the fall is synced
    task automatic frame(input int bits, input logic busy);
        u_dacl_host_model.beginFrame();
        check(36'({serial_out_a_oe, sampleHold}), 36'h3);
        check(36'(convBusy), 36'(busy));
        u_dacl_host_model.shiftBits(bits, capA, capB);
        u_dacl_host_model.endFrame();
        check(36'({serial_out_a_oe, convBusy}), 36'h0);
        check(36'(frameClockCount), 36'(bits));
        @(negedge clock);
    endtask

    initial begin
        {rst_n, cfgWrite, softReset, hardReset, selfTestOk} = 5'h01;
        {extra_bits_enable, osModeEnable, output_lane_select} = 3'h0;
        {limit_pin_enable, power_down_select, reference_source_select} = 3'h0;
        {resultA, resultB, lower_limit_value} = '0;
        upper_limit_value = 18'h3ffff;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        check(36'({selftest_fail_flag, limit_flag_register}), 36'h0);
        // table: capture frame, then flags, then read-back frame
        foreach (rows[r]) begin
            w = rows[r];
            {upper_limit_value, lower_limit_value} = {w.up, w.lo};
            {output_lane_select, extra_bits_enable, osModeEnable} =
                {w.lane, w.xb, w.os};
            writeCfg();
            {resultA, resultB} = {w.a, w.b};
            ext = w.xb & w.os;
            n = w.lane ? (ext ? 36 : 32) : (ext ? 18 : 16);
            frame(n, 1'b1);
            expB = 36'({w.b < w.lo, w.b > w.up, w.a < w.lo, w.a > w.up});
            check(36'(limit_flag_register), expB);
            frame(n, 1'b1);
            expA = ext ? 36'(w.a) : 36'(w.a[17:2]);
            expB = ext ? 36'(w.b) : 36'(w.b[17:2]);
            if (w.lane) begin
                expA = ext ? {w.a, w.b} : 36'({expA[15:0], expB[15:0]});
            end else begin
                check(capB, expB);
            end
            check(capA, expA);
        end
        // flag pin mode
        {upper_limit_value, lower_limit_value} = {18'h20000, 18'h00100};
        {output_lane_select, limit_pin_enable} = 2'h3;
        {extra_bits_enable, osModeEnable} = 2'h0;
        writeCfg();
        {resultA, resultB} = {18'h3ffff, 18'h10000};
        frame(32, 1'b1);
        check(36'(flagPin), 36'h1);
        u_dacl_host_model.beginFrame();
        check(36'(flagPin), 36'h0);
        u_dacl_host_model.shiftBits(32, capA, capB);
        u_dacl_host_model.endFrame();
        @(negedge clock);
        {resultA, resultB} = {18'h10000, 18'h00000};
        frame(32, 1'b1);
        check(36'({flagPin, limit_flag_register}), 36'h18);
        // soft reset drops flags but keeps the limits
        softReset = 1'b1;
        @(negedge clock);
        softReset = 1'b0;
        repeat (3) @(negedge clock);
        check(36'(limit_flag_register), 36'h0);
        frame(32, 1'b1);
        check(36'(limit_flag_register), 36'h8);
        // shutdown: no conversion, serial port still answers
        power_down_select = 1'b1;
        writeCfg();
        @(negedge clock);
        check(36'({analogPowerOn, internalRefEnable}), 36'h0);
        resultA = 18'h00000;
        frame(32, 1'b0);
        check(36'(limit_flag_register), 36'h8);
        {power_down_select, reference_source_select} = 2'h1;
        writeCfg();
        @(negedge clock);
        check(36'({analogPowerOn, internalRefEnable}), 36'h2);
        reference_source_select = 1'b0;
        writeCfg();
        repeat (20) @(negedge clock);
        check(36'(internalRefEnable), 36'h1);
        frame(32, 1'b1);
        check(36'(limit_flag_register), 36'ha);
        frame(4, 1'b1);
        check(36'(shortAccess), 36'h1);
        frame(36, 1'b1);
        check(36'(shortAccess), 36'h0);
        // hard reset with failing self test, then a clean retry
        {selfTestOk, hardReset} = 2'h1;
        @(negedge clock);
        hardReset = 1'b0;
        repeat (10) @(negedge clock);
        check(36'({selftest_fail_flag, limit_flag_register}), 36'h10);
        frame(16, 1'b1);
        check(36'(limit_flag_register), 36'h0);
        {selfTestOk, hardReset} = 2'h3;
        @(negedge clock);
        hardReset = 1'b0;
        repeat (10) @(negedge clock);
        check(36'(selftest_fail_flag), 36'h0);
        completeRun();
    end
endmodule
